// [pkg/aea_pkg.sv]
// constants, register map and carrier types of the active energy accumulator
// assumes a 20 MHz pclk and an APB master with 32-bit data
package aea_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TOTAL = 8'h01;
  localparam logic [7:0] IDX_RCLR  = 8'h02;
  localparam logic [7:0] IDX_DIV   = 8'h03;
  localparam logic [7:0] IDX_LCE   = 8'h04;
  localparam logic [7:0] IDX_LCT   = 8'h05;
  localparam logic [7:0] IDX_WDATA = 8'h06;
  localparam logic [7:0] IDX_WAVE  = 8'h0D;
  localparam logic [7:0] IDX_NL    = 8'h0E;
  localparam logic [7:0] IDX_ACC   = 8'h0F;
  localparam logic [7:0] IDX_IRQEN = 8'hDB;
  localparam logic [7:0] IDX_IRQST = 8'hDE;
  // field positions
  localparam int ACC_POS_BIT  = 1;
  localparam int ACC_ABS_BIT  = 2;
  localparam int IRQ_HALF     = 0;
  localparam int IRQ_OVF      = 1;
  localparam int IRQ_CYC      = 2;
  localparam int IRQ_WFS      = 3;
  localparam int IRQ_SIGN     = 4;
  localparam int IRQ_NOLOAD   = 5;
  localparam int WAVE_RATE_LO = 3;
  localparam logic [2:0] WAVE_SRC_POWER = 3'h0;
  // reset values
  localparam logic [7:0]  RST_CFG8  = 8'h00;
  localparam logic [15:0] RST_LCT   = 16'h0000;
  // widths
  localparam int ACC_W = 49;
  localparam int TOP_W = 24;
  localparam int SMP_W = 24;
  // timing
  localparam int CLK_NS         = 50;
  localparam int ACC_PERIOD_CYC = 5;
  localparam int WAVE_PERIOD_NS = 35842;
  localparam int WAVE_CYC       = WAVE_PERIOD_NS / CLK_NS;
  localparam int PULSE_LOW_NS   = 100000;
  localparam int PULSE_LOW_CYC  = PULSE_LOW_NS / CLK_NS;
  localparam logic signed [31:0] PULSE_THRESH = 32'sh0010_0000;
  // no-load thresholds on the multiplier output
  localparam logic [SMP_W-1:0] NL_TH1 = 24'h00007E;
  localparam logic [SMP_W-1:0] NL_TH2 = 24'h00003F;
  localparam logic [SMP_W-1:0] NL_TH3 = 24'h00001F;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aea_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aea_apb_rsp_t;
endpackage

// [verilog/aea_divider.sv]
// unsigned divider of the power magnitude by the energy divider value
// assumes start pulses no closer than two cycles apart
`timescale 1ns/1ps
`default_nettype none
module aea_divider
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      start,
  input  wire logic [aea_pkg::SMP_W-1:0] dividend,
  input  wire logic [7:0]                divisor,
  output logic      [aea_pkg::SMP_W-1:0] quotient,
  output logic                           done
);
  typedef struct packed {
    logic [aea_pkg::SMP_W-1:0] q;
    logic                      v;
  } aea_div_st_t;

  aea_div_st_t st_ff;
  aea_div_st_t nxt_st;
  logic [aea_pkg::SMP_W-1:0] dvs;

  always_comb
  begin
    nxt_st = st_ff;
    dvs = {16'h0000, divisor};
    if (divisor == 8'h00)
    begin
      dvs = 24'h000001; // zero acts as one
    end
    nxt_st.v = start;
    if (start)
    begin
      nxt_st.q = dividend / dvs;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign quotient = st_ff.q;
  assign done     = st_ff.v;
endmodule
`default_nettype wire

// [verilog/aea_top.sv]
// active energy accumulator with APB register slave
// assumes power_in is gain-calibrated and synchronous to pclk,
// zero_cross is a one-cycle pulse per voltage zero crossing
`timescale 1ns/1ps
`default_nettype none
module aea_top
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire aea_pkg::aea_apb_req_t        apb_req,
  output aea_pkg::aea_apb_rsp_t             apb_rsp,
  input  wire logic [aea_pkg::SMP_W-1:0]    power_in,
  input  wire logic                         zero_cross,
  output logic      [aea_pkg::SMP_W-1:0]    wave_data,
  output logic                              wave_valid,
  output logic                              energy_pulse_out_n,
  output logic                              irq
);
  typedef struct packed {
    aea_pkg::aea_apb_rsp_t      rsp;
    logic [7:0]                 wave_cfg;
    logic [7:0]                 acc_cfg;
    logic [7:0]                 irq_en;
    logic [7:0]                 irq_st;
    logic [7:0]                 divider;
    logic [1:0]                 noload_cfg;
    logic [15:0]                lc_target;
    logic [15:0]                lc_count;
    logic                       lc_wait;
    logic [aea_pkg::ACC_W-1:0]  acc;
    logic [aea_pkg::ACC_W-1:0]  lc_acc;
    logic [aea_pkg::TOP_W-1:0]  lc_result;
    logic [2:0]                 tick;
    logic                       add_en;
    logic                       add_neg;
    logic                       prev_neg;
    logic [15:0]                wave_cnt;
    logic [2:0]                 wave_div;
    logic [aea_pkg::SMP_W-1:0]  wave_data;
    logic                       wave_valid;
    logic signed [31:0]         pulse_acc;
    logic [11:0]                pulse_cnt;
    logic                       pulse_n;
    logic                       irq;
  } aea_state_t;

  aea_state_t st_ff;
  aea_state_t nxt_st;

  logic                       div_start;
  logic [aea_pkg::SMP_W-1:0]  div_q;
  logic                       div_done;
  logic                       p_neg;
  logic [aea_pkg::SMP_W-1:0]  p_mag;
  logic [aea_pkg::SMP_W-1:0]  nl_th;
  logic                       nl_hit;
  logic                       pos_only;
  logic                       abs_mode;
  logic                       setup;
  logic                       access;
  logic [9:0]                 idx;
  logic [aea_pkg::ACC_W-1:0]  contrib;
  logic [aea_pkg::ACC_W-1:0]  base;
  logic [aea_pkg::ACC_W-1:0]  sum;
  logic                       rclr;
  logic [7:0]                 ev;
  logic [7:0]                 clr;
  logic                       wtick;
  logic                       lc_end;
  logic [31:0]                rd;
  logic                       hit;

  assign p_neg    = power_in[aea_pkg::SMP_W-1];
  assign p_mag    = p_neg ? (~power_in + 24'h000001) : power_in;
  assign pos_only = st_ff.acc_cfg[aea_pkg::ACC_POS_BIT];
  assign abs_mode = st_ff.acc_cfg[aea_pkg::ACC_ABS_BIT] && !pos_only;
  assign setup    = apb_req.psel && !apb_req.penable;
  assign access   = apb_req.psel && apb_req.penable;
  assign idx      = apb_req.paddr[11:2];
  assign div_start = (st_ff.tick == 3'(aea_pkg::ACC_PERIOD_CYC - 1));

  always_comb
  begin
    case (st_ff.noload_cfg)
      2'b01:   nl_th = aea_pkg::NL_TH1;
      2'b10:   nl_th = aea_pkg::NL_TH2;
      2'b11:   nl_th = aea_pkg::NL_TH3;
      default: nl_th = 24'h000000;
    endcase
  end
  assign nl_hit = (p_mag < nl_th);

  aea_divider u_div
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (div_start),
    .dividend (p_mag),
    .divisor  (st_ff.divider),
    .quotient (div_q),
    .done     (div_done)
  );

  // read mux, evaluated in the setup cycle
  always_comb
  begin
    rd  = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      10'(aea_pkg::IDX_TOTAL): rd = {8'h00, st_ff.acc[48:25]};
      10'(aea_pkg::IDX_RCLR):  rd = {8'h00, st_ff.acc[48:25]};
      10'(aea_pkg::IDX_DIV):   rd = {24'h000000, st_ff.divider};
      10'(aea_pkg::IDX_LCE):   rd = {8'h00, st_ff.lc_result};
      10'(aea_pkg::IDX_LCT):   rd = {16'h0000, st_ff.lc_target};
      10'(aea_pkg::IDX_WDATA): rd = {8'h00, st_ff.wave_data};
      10'(aea_pkg::IDX_WAVE):  rd = {24'h000000, st_ff.wave_cfg};
      10'(aea_pkg::IDX_NL):    rd = {30'h0, st_ff.noload_cfg};
      10'(aea_pkg::IDX_ACC):   rd = {24'h000000, st_ff.acc_cfg};
      10'(aea_pkg::IDX_IRQEN): rd = {24'h000000, st_ff.irq_en};
      10'(aea_pkg::IDX_IRQST): rd = {24'h000000, st_ff.irq_st};
      default:                 hit = 1'b0;
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    ev     = 8'h00;
    clr    = 8'h00;
    lc_end = 1'b0;
    rclr   = 1'b0;
    // APB: answer stands in the access cycle, zero wait states
    nxt_st.rsp.pready = setup;
    if (setup)
    begin
      nxt_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
      nxt_st.rsp.pslverr = !hit;
    end
    if (access && apb_req.pwrite)
    begin
      case (idx)
        10'(aea_pkg::IDX_DIV):   nxt_st.divider = apb_req.pwdata[7:0];
        10'(aea_pkg::IDX_WAVE):  nxt_st.wave_cfg = apb_req.pwdata[7:0];
        10'(aea_pkg::IDX_NL):    nxt_st.noload_cfg = apb_req.pwdata[1:0];
        10'(aea_pkg::IDX_ACC):   nxt_st.acc_cfg = apb_req.pwdata[7:0];
        10'(aea_pkg::IDX_IRQEN): nxt_st.irq_en = apb_req.pwdata[7:0];
        10'(aea_pkg::IDX_IRQST): clr = apb_req.pwdata[7:0];
        10'(aea_pkg::IDX_LCT):
        begin
          nxt_st.lc_target = apb_req.pwdata[15:0];
          nxt_st.lc_acc    = '0;
          nxt_st.lc_result = '0;
          nxt_st.lc_count  = 16'h0000;
          nxt_st.lc_wait   = 1'b1;
        end
        default: ;
      endcase
    end
    if (access && !apb_req.pwrite && idx == 10'(aea_pkg::IDX_RCLR))
    begin
      rclr = 1'b1;
    end

    // sample timing and mode decision
    nxt_st.tick = div_start ? 3'd0 : st_ff.tick + 3'd1;
    if (div_start)
    begin
      nxt_st.prev_neg = p_neg;
      if (p_neg && !st_ff.prev_neg)
      begin
        ev[aea_pkg::IRQ_SIGN] = 1'b1;
      end
      if (nl_hit)
      begin
        ev[aea_pkg::IRQ_NOLOAD] = 1'b1;
      end
      nxt_st.add_en  = !nl_hit && !(pos_only && p_neg);
      nxt_st.add_neg = p_neg && !abs_mode && !pos_only;
    end

    // accumulation, wraps in two's complement
    contrib = {25'h0, div_q};
    if (st_ff.add_neg)
    begin
      contrib = ~contrib + 49'h1;
    end
    base = st_ff.acc;
    if (rclr)
    begin
      base = {24'h000000, st_ff.acc[24:0]};
    end
    sum = base;
    if (div_done && st_ff.add_en)
    begin
      sum = base + contrib;
      if (!st_ff.add_neg && !base[48] && sum[48])
      begin
        ev[aea_pkg::IRQ_OVF] = 1'b1;
      end
      if (st_ff.add_neg && base[48] && !sum[48])
      begin
        ev[aea_pkg::IRQ_OVF] = 1'b1;
      end
      if ((sum[48] ^ sum[47]) && !(base[48] ^ base[47]))
      begin
        ev[aea_pkg::IRQ_HALF] = 1'b1;
      end
      nxt_st.pulse_acc = st_ff.pulse_acc + 32'(signed'(contrib[31:0]));
    end
    nxt_st.acc = sum;

    // pulse output, low for a fixed width per energy quantum
    if (st_ff.pulse_cnt != 12'h000)
    begin
      nxt_st.pulse_cnt = st_ff.pulse_cnt - 12'h001;
    end
    else if (st_ff.pulse_acc >= aea_pkg::PULSE_THRESH)
    begin
      nxt_st.pulse_acc = nxt_st.pulse_acc - aea_pkg::PULSE_THRESH;
      nxt_st.pulse_cnt = 12'(aea_pkg::PULSE_LOW_CYC);
    end
    else if (st_ff.pulse_acc <= -aea_pkg::PULSE_THRESH)
    begin
      nxt_st.pulse_acc = nxt_st.pulse_acc + aea_pkg::PULSE_THRESH;
      nxt_st.pulse_cnt = 12'(aea_pkg::PULSE_LOW_CYC);
    end
    nxt_st.pulse_n = (nxt_st.pulse_cnt == 12'h000);

    // line-cycle accumulation on the same contribution
    if (st_ff.lc_target != 16'h0000 && !st_ff.lc_wait && div_done && st_ff.add_en)
    begin
      nxt_st.lc_acc = st_ff.lc_acc + contrib;
    end
    if (zero_cross && st_ff.lc_target != 16'h0000)
    begin
      if (st_ff.lc_wait)
      begin
        nxt_st.lc_wait = 1'b0;
      end
      else
      begin
        nxt_st.lc_count = st_ff.lc_count + 16'h0001;
        if (st_ff.lc_count + 16'h0001 == st_ff.lc_target)
        begin
          lc_end = 1'b1;
        end
      end
    end
    if (lc_end)
    begin
      nxt_st.lc_result = nxt_st.lc_acc[48:25];
      nxt_st.lc_acc    = '0;
      nxt_st.lc_count  = 16'h0000;
      ev[aea_pkg::IRQ_CYC] = 1'b1;
    end

    // waveform sampling of active power
    wtick = (st_ff.wave_cnt == 16'(aea_pkg::WAVE_CYC - 1));
    nxt_st.wave_valid = 1'b0;
    nxt_st.wave_cnt = wtick ? 16'h0000 : st_ff.wave_cnt + 16'h0001;
    if (wtick)
    begin
      nxt_st.wave_div = st_ff.wave_div + 3'd1;
      if (st_ff.irq_en[aea_pkg::IRQ_WFS] &&
          st_ff.wave_cfg[2:0] == aea_pkg::WAVE_SRC_POWER)
      begin
        case (st_ff.wave_cfg[aea_pkg::WAVE_RATE_LO +: 2])
          2'b00:   nxt_st.wave_valid = 1'b1;
          2'b01:   nxt_st.wave_valid = (st_ff.wave_div[0] == 1'b0);
          2'b10:   nxt_st.wave_valid = (st_ff.wave_div[1:0] == 2'b00);
          default: nxt_st.wave_valid = (st_ff.wave_div == 3'd0);
        endcase
        if (nxt_st.wave_valid)
        begin
          nxt_st.wave_data = power_in;
        end
      end
    end

    // sticky status, a new event wins over a clear
    nxt_st.irq_st = (st_ff.irq_st & ~clr) | ev;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en &
                   ~(8'h01 << aea_pkg::IRQ_WFS));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff            <= '0;
      st_ff.wave_cfg   <= aea_pkg::RST_CFG8;
      st_ff.acc_cfg    <= aea_pkg::RST_CFG8;
      st_ff.irq_en     <= aea_pkg::RST_CFG8;
      st_ff.lc_target  <= aea_pkg::RST_LCT;
      st_ff.pulse_n    <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign apb_rsp            = st_ff.rsp;
  assign wave_data          = st_ff.wave_data;
  assign wave_valid         = st_ff.wave_valid;
  assign energy_pulse_out_n = st_ff.pulse_n;
  assign irq                = st_ff.irq;
endmodule
`default_nettype wire

// [tb/aea_top_sva.sv]
// port assertions of the active energy accumulator
// bound to aea_top, single pclk domain with async presetn
`timescale 1ns/1ps
`default_nettype none
module aea_top_sva
(
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire aea_pkg::aea_apb_req_t     apb_req,
  input wire aea_pkg::aea_apb_rsp_t     apb_rsp,
  input wire logic [aea_pkg::SMP_W-1:0] power_in,
  input wire logic                      zero_cross,
  input wire logic [aea_pkg::SMP_W-1:0] wave_data,
  input wire logic                      wave_valid,
  input wire logic                      energy_pulse_out_n,
  input wire logic                      irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc_f;
  logic        rd_f;
  logic        mapped;
  logic [7:0]  idx;
  logic [11:0] low_cnt_ff;
  logic [7:0]  cfg_ff;
  assign acc_f  = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign rd_f   = acc_f && !apb_req.pwrite;
  assign idx    = apb_req.paddr[9:2];
  assign mapped = (apb_req.paddr[11:10] == 2'h0) && (idx inside {aea_pkg::IDX_TOTAL,
                  aea_pkg::IDX_RCLR, aea_pkg::IDX_DIV, aea_pkg::IDX_LCE, aea_pkg::IDX_LCT,
                  aea_pkg::IDX_WDATA, aea_pkg::IDX_WAVE, aea_pkg::IDX_NL, aea_pkg::IDX_ACC,
                  aea_pkg::IDX_IRQEN, aea_pkg::IDX_IRQST});
  // low time of the pulse output and last mode written
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      low_cnt_ff <= 12'h000;
      cfg_ff     <= 8'h00;
    end
    else
    begin
      low_cnt_ff <= energy_pulse_out_n ? 12'h000 : low_cnt_ff + 12'h001;
      if (acc_f && apb_req.pwrite && mapped && idx == aea_pkg::IDX_ACC)
        cfg_ff <= apb_req.pwdata[7:0];
    end
  a_pready_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside an access cycle");
  a_zero_wait: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("first access cycle without pready");
  a_unmapped_err: assert property (acc_f && !mapped |->
    apb_rsp.pslverr && (apb_req.pwrite || apb_rsp.prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc_f && mapped |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  a_read_upper: assert property (rd_f |-> apb_rsp.prdata[31:24] == 8'h00)
    else $error("read data above bit 23");
  a_mode_readback: assert property (rd_f && mapped && idx == aea_pkg::IDX_ACC |->
    apb_rsp.prdata[2:1] == cfg_ff[2:1])
    else $error("mode bits read back wrong");
  a_pulse_width: assert property ($rose(energy_pulse_out_n) |-> low_cnt_ff >= 12'h7D0)
    else $error("energy pulse too short");
  a_wave_single: assert property (wave_valid |=> !wave_valid [*8])
    else $error("waveform strobe repeated");
  a_wave_change: assert property ($changed(wave_data) |-> wave_valid)
    else $error("waveform data changed without strobe");
  a_wave_power: assert property (wave_valid |-> wave_data == $past(power_in))
    else $error("waveform sample is not the power input");
  c_pulse: cover property ($fell(energy_pulse_out_n));
  c_wave: cover property (wave_valid);
  c_irq: cover property ($rose(irq));
  c_cycle_irq: cover property (zero_cross ##[1:4] $rose(irq));
endmodule
bind aea_top aea_top_sva u_sva
(
  .pclk               (pclk),
  .presetn            (presetn),
  .apb_req            (apb_req),
  .apb_rsp            (apb_rsp),
  .power_in           (power_in),
  .zero_cross         (zero_cross),
  .wave_data          (wave_data),
  .wave_valid         (wave_valid),
  .energy_pulse_out_n (energy_pulse_out_n),
  .irq                (irq)
);
`default_nettype wire

// [tb/aea_mcu_model.sv]
// register-reading core model: APB master issuing one transfer per call
// assumes pclk is the slave's clock; waits on pready without a fixed count
`timescale 1ns/1ps
`default_nettype none
module aea_mcu_model
(
  input  wire logic                  pclk,
  output var aea_pkg::aea_apb_req_t  apb_req,
  input  wire aea_pkg::aea_apb_rsp_t apb_rsp
);
  initial apb_req = '0;
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the active energy accumulator
// drives power and zero crossings, registers through the core model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [23:0] PMAX = 24'h7FFFFF;
  localparam logic [23:0] NMAX = 24'h800001;
  typedef struct packed {logic [7:0] cfg; logic [7:0] dv; logic [23:0] pw; logic [1:0] cl;}
    aea_row_t;
  // class 0 zero, 1 positive, 2 negative total
  aea_row_t rows [7] = '{'{8'h00, 8'hFF, PMAX, 2'h0}, '{8'h00, 8'h00, PMAX, 2'h1},
    '{8'h00, 8'h01, NMAX, 2'h2}, '{8'h02, 8'h01, NMAX, 2'h0}, '{8'h02, 8'h01, PMAX, 2'h1},
    '{8'h04, 8'h01, NMAX, 2'h1}, '{8'h06, 8'h01, NMAX, 2'h0}};
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  aea_pkg::aea_apb_req_t apb_req;
  aea_pkg::aea_apb_rsp_t apb_rsp;
  logic [23:0]           power_in = 24'h0;
  logic                  zero_cross = 1'b0;
  logic [23:0]           wave_data;
  logic                  wave_valid;
  logic                  pulse_n;
  logic                  irq;
  logic [31:0]           rd;
  logic [31:0]           t;
  logic                  er;
  logic                  hi_bad = 1'b0;
  longint                t0;
  int                    n;
  int                    cyc = 0;
  int                    checks = 0;
  int                    mismatches = 0;
  always #25 pclk = ~pclk;
  aea_mcu_model u_mcu
  (
    .pclk    (pclk),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp)
  );
  aea_top DUT
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .apb_req            (apb_req),
    .apb_rsp            (apb_rsp),
    .power_in           (power_in),
    .zero_cross         (zero_cross),
    .wave_data          (wave_data),
    .wave_valid         (wave_valid),
    .energy_pulse_out_n (pulse_n),
    .irq                (irq)
  );
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    u_mcu.xfer(1'b1, idx, d, rd, er);
  endtask
  task automatic rdr(input logic [7:0] idx);
    u_mcu.xfer(1'b0, idx, 32'h0, rd, er);
  endtask
  task automatic zc(input int gap);
    @(posedge pclk);
    zero_cross <= 1'b1;
    @(posedge pclk);
    zero_cross <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  task automatic wait_valid;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (wave_valid !== 1'b1 && n < 7000);
  endtask
  function automatic logic [31:0] cls(input logic [31:0] v);
    return (v[23:0] == 24'h0) ? 32'h0 : (v[23] ? 32'h2 : 32'h1);
  endfunction
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      summarize();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdr(aea_pkg::IDX_ACC);
    chk(rd, 32'h0, "mode reset");
    rdr(aea_pkg::IDX_LCT);
    chk(rd, 32'h0, "target reset");
    rdr(aea_pkg::IDX_TOTAL);
    chk(rd, 32'h0, "total reset");
    chk({31'h0, pulse_n, irq}, 32'h2, "pulse and irq idle");
    rdr(8'h20);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    // negative power must give no pulse in positive-only mode
    wr(aea_pkg::IDX_ACC, 32'h2);
    power_in <= 24'hFFF830;
    repeat (300)
    begin
      @(posedge pclk);
      if (pulse_n !== 1'b1)
        hi_bad = 1'b1;
    end
    chk({31'h0, hi_bad}, 32'h0, "pulse from ignored power");
    wr(aea_pkg::IDX_ACC, 32'h0);
    power_in <= 24'h0007D0;
    n = 0;
    while (pulse_n !== 1'b0 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, pulse_n}, 32'h0, "pulse after quantum");
    foreach (rows[i])
    begin
      wr(aea_pkg::IDX_ACC, {24'h0, rows[i].cfg});
      wr(aea_pkg::IDX_DIV, {24'h0, rows[i].dv});
      power_in <= rows[i].pw;
      repeat (100) @(posedge pclk);
      power_in <= 24'h0;
      repeat (10) @(posedge pclk);
      rdr(aea_pkg::IDX_TOTAL);
      t = rd;
      chk(cls(t), {30'h0, rows[i].cl}, "total class");
      rdr(aea_pkg::IDX_RCLR);
      chk(rd, t, "read-clear value");
      rdr(aea_pkg::IDX_TOTAL);
      chk(rd, 32'h0, "total after read-clear");
    end
    rdr(aea_pkg::IDX_IRQST);
    chk({31'h0, rd[aea_pkg::IRQ_SIGN]}, 32'h1, "sign change flag");
    wr(aea_pkg::IDX_IRQST, 32'hFF);
    wr(aea_pkg::IDX_NL, 32'h1);
    wr(aea_pkg::IDX_ACC, 32'h4);
    power_in <= 24'h000064;
    repeat (20) @(posedge pclk);
    rdr(aea_pkg::IDX_IRQST);
    chk({31'h0, rd[aea_pkg::IRQ_NOLOAD]}, 32'h1, "no-load flag");
    // lowest threshold lets the same power through
    wr(aea_pkg::IDX_NL, 32'h3);
    wr(aea_pkg::IDX_IRQST, 32'hFF);
    repeat (20) @(posedge pclk);
    rdr(aea_pkg::IDX_IRQST);
    chk({31'h0, rd[aea_pkg::IRQ_NOLOAD]}, 32'h0, "no-load flag at low level");
    wr(aea_pkg::IDX_NL, 32'h0);
    wr(aea_pkg::IDX_ACC, 32'h0);
    wr(aea_pkg::IDX_IRQST, 32'hFF);
    wr(aea_pkg::IDX_IRQEN, 32'h4);
    power_in <= PMAX;
    wr(aea_pkg::IDX_LCT, 32'h2);
    repeat (50) @(posedge pclk);
    rdr(aea_pkg::IDX_LCE);
    chk(rd, 32'h0, "line energy before start");
    zc(40);
    zc(40);
    rdr(aea_pkg::IDX_IRQST);
    chk({31'h0, rd[aea_pkg::IRQ_CYC]}, 32'h0, "early done");
    zc(5);
    rdr(aea_pkg::IDX_IRQST);
    chk({31'h0, rd[aea_pkg::IRQ_CYC]}, 32'h1, "done at target");
    chk({31'h0, irq}, 32'h1, "irq held");
    power_in <= 24'h0;
    rdr(aea_pkg::IDX_LCE);
    chk(cls(rd), 32'h1, "line energy");
    wr(aea_pkg::IDX_IRQST, 32'h4);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    zc(5);
    zc(5);
    rdr(aea_pkg::IDX_IRQST);
    chk({31'h0, rd[aea_pkg::IRQ_CYC]}, 32'h1, "next period done");
    wr(aea_pkg::IDX_IRQEN, 32'h0);
    power_in <= 24'h123456;
    for (int r = 0; r < 4; r++)
    begin
      // sampling off while the rate changes, so no stale strobe is timed
      wr(aea_pkg::IDX_IRQEN, 32'h0);
      wr(aea_pkg::IDX_WAVE, 32'(r << aea_pkg::WAVE_RATE_LO));
      wr(aea_pkg::IDX_IRQEN, 32'h8);
      wait_valid();
      t0 = $time;
      chk({8'h0, wave_data}, 32'h00123456, "waveform sample");
      wait_valid();
      chk(32'(($time - t0) / 50), 32'(aea_pkg::WAVE_CYC << r), "sample spacing");
    end
    summarize();
  end
endmodule
`default_nettype wire
